// file: ebms_pkg.sv
package ebms_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 8;
  localparam int NUM_CS = 4;
  localparam int LEN_W  = 4;
  localparam int CS_W   = 2;

  // bus formats per chip select
  typedef enum logic [1:0] {
    EBMS_NATIVE = 2'h0,
    EBMS_THREE  = 2'h1,
    EBMS_FOUR   = 2'h2
  } ebms_fmt_t;

  localparam logic [LEN_W-1:0] LEN_MIN   = 4'h1;
  localparam logic [LEN_W-1:0] LEN_RESET = 4'h1;

  // per chip select configuration
  typedef struct packed {
    ebms_fmt_t          fmt;
    logic               muxed;
    logic [LEN_W-1:0]   len;
  } ebms_cfg_t;

  // cycle request from the processor side
  typedef struct packed {
    logic               valid;
    logic               write;
    logic               io;
    logic [CS_W-1:0]    cs;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  wdata;
  } ebms_req_t;

  // external bus outputs, active low strobes except the active high latch strobe ale
  typedef struct packed {
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  dout;
    logic               doe;
    logic [NUM_CS-1:0]  chip_select_line_n;
    logic               memory_request_n;
    logic               io_request_n;
    logic               rd_n;
    logic               wr_n;
    logic               ale;
  } ebms_bus_t;

  localparam logic [NUM_CS-1:0] CS_IDLE = 4'hf;

endpackage : ebms_pkg

// file: ebms_sequencer.sv
`timescale 1ns/100ps
module ebms_sequencer (
  input  wire logic                              sys_clk,
  input  wire logic                              rst_n,
  input  wire ebms_pkg::ebms_cfg_t [ebms_pkg::NUM_CS-1:0] cfg,
  input  wire ebms_pkg::ebms_req_t               req,
  output logic                                   req_ready,
  output logic                                   done,
  output logic [ebms_pkg::DATA_W-1:0]            rdata,
  output ebms_pkg::ebms_bus_t                    bus,
  input  wire logic [ebms_pkg::DATA_W-1:0]       data_in,
  input  wire logic                              wait_n
);

  typedef enum logic [2:0] {ST_IDLE, ST_T1, ST_T2, ST_WAIT, ST_T3, ST_T4, ST_NATIVE}
    ebms_state_t;

  typedef struct packed {
    ebms_state_t                      st;
    logic [ebms_pkg::LEN_W-1:0]       cnt;
    logic [ebms_pkg::LEN_W-1:0]       len;
    ebms_pkg::ebms_fmt_t              fmt;
    logic                             muxed;
    logic                             write;
    logic                             io;
    logic [ebms_pkg::CS_W-1:0]        cs;
    logic [ebms_pkg::ADDR_W-1:0]      addr;
    logic [ebms_pkg::DATA_W-1:0]      wdata;
    logic                             wait_seen;
    logic                             done;
    logic [ebms_pkg::DATA_W-1:0]      rdata;
    ebms_pkg::ebms_bus_t              bus;
  } ebms_reg_t;

  ebms_reg_t r;
  ebms_reg_t next_r;
  logic      last_clk;
  logic [ebms_pkg::LEN_W-1:0] half;

  // position inside the current state
  assign last_clk  = (r.cnt == r.len);
  assign half      = r.len >> 1;
  assign req_ready = (r.st == ST_IDLE);
  assign done      = r.done;
  assign rdata     = r.rdata;
  assign bus       = r.bus;

  // state sequencing and bus shaping
  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    next_r.cnt  = r.cnt + 4'h1;
    case (r.st)
      ST_IDLE: begin
        next_r.cnt = ebms_pkg::LEN_MIN;
        // all strobes idle between cycles
        next_r.bus.chip_select_line_n = ebms_pkg::CS_IDLE;
        next_r.bus.rd_n               = 1'b1;
        next_r.bus.wr_n               = 1'b1;
        next_r.bus.memory_request_n   = 1'b1;
        next_r.bus.io_request_n       = 1'b1;
        next_r.bus.ale                = 1'b0;
        next_r.bus.doe                = 1'b0;
        if (req.valid) begin
          next_r.fmt   = cfg[req.cs].fmt;
          next_r.muxed = cfg[req.cs].muxed;
          // zero length is taken as the shortest state
          next_r.len   = (cfg[req.cs].len < ebms_pkg::LEN_MIN) ?
                         ebms_pkg::LEN_MIN : cfg[req.cs].len;
          next_r.write = req.write;
          next_r.io    = req.io;
          next_r.cs    = req.cs;
          next_r.addr  = req.addr;
          next_r.wdata = req.wdata;
          next_r.wait_seen = 1'b0;
          next_r.bus.addr = req.addr;
          next_r.bus.chip_select_line_n[req.cs] = 1'b0;
          next_r.bus.dout = req.wdata;
          next_r.bus.doe  = req.write;
          if (cfg[req.cs].fmt == ebms_pkg::EBMS_NATIVE) begin
            // native cycle: strobes straight away, held for one clock or until wait goes high
            next_r.st = ST_NATIVE;
            next_r.bus.memory_request_n = req.io;
            next_r.bus.io_request_n     = ~req.io;
            next_r.bus.rd_n             = req.write;
            next_r.bus.wr_n             = ~req.write;
          end else begin
            next_r.st = ST_T1;
            if (cfg[req.cs].fmt == ebms_pkg::EBMS_FOUR) begin
              next_r.bus.ale = 1'b1;
              if (cfg[req.cs].muxed) begin
                next_r.bus.dout = req.addr[ebms_pkg::DATA_W-1:0];
                next_r.bus.doe  = 1'b1;
              end
            end
          end
        end
      end
      ST_NATIVE: begin
        if (!wait_n) begin
          next_r.cnt = r.cnt;
        end else begin
          if (!r.write) begin
            next_r.rdata = data_in;
          end
          next_r.done = 1'b1;
          next_r.st   = ST_IDLE;
          next_r.bus.chip_select_line_n = ebms_pkg::CS_IDLE;
          next_r.bus.rd_n               = 1'b1;
          next_r.bus.wr_n               = 1'b1;
          next_r.bus.memory_request_n   = 1'b1;
          next_r.bus.io_request_n       = 1'b1;
          next_r.bus.doe                = 1'b0;
        end
      end
      ST_T1: begin
        // latch strobe falls at mid state
        if (r.fmt == ebms_pkg::EBMS_FOUR && r.cnt >= half) begin
          next_r.bus.ale = 1'b0;
        end
        if (last_clk) begin
          next_r.st  = ST_T2;
          next_r.cnt = ebms_pkg::LEN_MIN;
          next_r.bus.ale              = 1'b0;
          next_r.bus.memory_request_n = r.io;
          next_r.bus.io_request_n     = ~r.io;
          next_r.bus.rd_n             = r.write;
          next_r.bus.wr_n             = ~r.write;
          // multiplexed: address leaves the data bus in T2
          next_r.bus.dout = r.wdata;
          next_r.bus.doe  = r.write;
        end
      end
      ST_T2: begin
        if (last_clk) begin
          next_r.cnt = ebms_pkg::LEN_MIN;
          // wait sampled on the last clock of T2 for both formats
          next_r.st  = !wait_n ? ST_WAIT : ST_T3;
        end
      end
      ST_WAIT: begin
        // one inserted_delay_state per clock while wait held low
        next_r.cnt = ebms_pkg::LEN_MIN;
        if (wait_n) begin
          next_r.st = ST_T3;
        end
      end
      ST_T3: begin
        // bus held unchanged through T3
        if (last_clk) begin
          next_r.cnt = ebms_pkg::LEN_MIN;
          if (r.fmt == ebms_pkg::EBMS_THREE) begin
            if (!r.write) begin
              next_r.rdata = data_in;
            end
            next_r.done = 1'b1;
            next_r.st   = ST_IDLE;
            next_r.bus.chip_select_line_n = ebms_pkg::CS_IDLE;
            next_r.bus.rd_n               = 1'b1;
            next_r.bus.wr_n               = 1'b1;
            next_r.bus.memory_request_n   = 1'b1;
            next_r.bus.io_request_n       = 1'b1;
            next_r.bus.doe                = 1'b0;
          end else begin
            next_r.st = ST_T4;
            if (!r.write) begin
              next_r.rdata = data_in;
            end
            next_r.bus.rd_n = 1'b1;
            next_r.bus.wr_n = 1'b1;
          end
        end
      end
      ST_T4: begin
        if (last_clk) begin
          next_r.done = 1'b1;
          next_r.st   = ST_IDLE;
          next_r.bus.chip_select_line_n = ebms_pkg::CS_IDLE;
          next_r.bus.memory_request_n   = 1'b1;
          next_r.bus.io_request_n       = 1'b1;
          next_r.bus.doe                = 1'b0;
        end
      end
      default: begin
        next_r.st = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r     <= '0;
      r.st  <= ST_IDLE;
      r.len <= ebms_pkg::LEN_RESET;
      r.cnt <= ebms_pkg::LEN_MIN;
      r.bus.chip_select_line_n <= ebms_pkg::CS_IDLE;
      r.bus.memory_request_n   <= 1'b1;
      r.bus.io_request_n       <= 1'b1;
      r.bus.rd_n               <= 1'b1;
      r.bus.wr_n               <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // three-state read asserts read strobe in T2
  AST_TS_READ_STROBE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.st == ST_T2 && r.fmt == ebms_pkg::EBMS_THREE && !r.write) |->
      (!bus.rd_n && bus.wr_n))
    else $error("read strobe missing in three-state T2");

  AST_TS_WRITE_STROBE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.st == ST_T2 && r.fmt == ebms_pkg::EBMS_THREE && r.write) |->
      (!bus.wr_n && bus.rd_n && (bus.io_request_n != bus.memory_request_n)))
    else $error("write strobe missing in three-state T2");

  AST_T1_SELECT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.st == ST_T1) |-> (bus.chip_select_line_n[r.cs] == 1'b0 && bus.addr == r.addr
      && bus.rd_n && bus.wr_n))
    else $error("chip select or address wrong in T1");

  AST_T3_STABLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.st == ST_T3 && $past(r.st) == ST_T3) |-> $stable(bus))
    else $error("bus changed during T3");

  AST_WAIT_ENTRY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.st == ST_T2 && last_clk && !wait_n) |=> (r.st == ST_WAIT))
    else $error("wait not inserted");

  AST_WAIT_EXIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.st == ST_WAIT && wait_n) |=> (r.st == ST_T3))
    else $error("wait state not left when ready high");

  AST_TS_CAPTURE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.st == ST_T3 && last_clk && r.fmt == ebms_pkg::EBMS_THREE && !r.write) |=>
      (done && rdata == $past(data_in)))
    else $error("three-state read data not captured");

  AST_FS_T4: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.st == ST_T3 && last_clk && r.fmt == ebms_pkg::EBMS_FOUR && !r.write) |=>
      (r.st == ST_T4 && bus.rd_n && rdata == $past(data_in)))
    else $error("four-state read capture wrong");

  AST_MUX_ADDR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.st == ST_T1 && r.fmt == ebms_pkg::EBMS_FOUR && r.muxed) |->
      (bus.doe && bus.dout == r.addr[ebms_pkg::DATA_W-1:0]))
    else $error("low address byte not on data bus");

  AST_ALE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.st == ST_IDLE && req.valid && cfg[req.cs].fmt == ebms_pkg::EBMS_FOUR) |=>
      (bus.ale ##1 (r.st != ST_T2 || !bus.ale)))
    else $error("latch strobe not raised at T1");

  AST_END_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (done && r.st == ST_IDLE) |-> (bus.chip_select_line_n == ebms_pkg::CS_IDLE
      && bus.rd_n && bus.wr_n && bus.memory_request_n && bus.io_request_n))
    else $error("strobes held after cycle end");

  // four-state read asserts read strobe and one request strobe in T2
  AST_FS_READ_STROBE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.st == ST_T2 && r.fmt == ebms_pkg::EBMS_FOUR && !r.write) |->
      (!bus.rd_n && bus.wr_n && (bus.io_request_n != bus.memory_request_n)))
    else $error("read strobe missing in four-state T2");

  // four-state T3 keeps the bus frozen
  AST_FS_T3_STABLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.st == ST_T3 && $past(r.st) == ST_T3 && r.fmt == ebms_pkg::EBMS_FOUR) |->
      $stable(bus))
    else $error("bus changed during four-state T3");

  // ready low before T3 begins inserts a wait state
  AST_FS_WAIT_ENTRY: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.st == ST_T2 && last_clk && !wait_n && r.fmt == ebms_pkg::EBMS_FOUR) |=>
      (r.st == ST_WAIT))
    else $error("four-state wait not inserted");

  // wait state held with a frozen bus while wait stays low
  AST_WAIT_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.st == ST_WAIT && !wait_n) |=> (r.st == ST_WAIT && $stable(bus)))
    else $error("wait state left while wait low");

  // state counter never runs past the programmed length outside idle
  AST_CNT_RANGE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.st != ST_IDLE) |-> (r.cnt <= r.len && r.len >= ebms_pkg::LEN_MIN))
    else $error("state counter out of range");

  // native cycle shows its strobes and chip select at once
  AST_NATIVE_STROBE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.st == ST_NATIVE) |-> ((!bus.rd_n || !bus.wr_n)
      && bus.chip_select_line_n != ebms_pkg::CS_IDLE))
    else $error("native cycle strobes missing");

  // multiplexed read frees the data bus once T2 starts
  AST_MUX_RELEASE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.st == ST_T2 && r.fmt == ebms_pkg::EBMS_FOUR && r.muxed && !r.write) |->
      !bus.doe)
    else $error("address left on data bus in T2");

  // four-state cycle completes right after the last T4 clock
  AST_FS_DONE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.st == ST_T4 && last_clk) |=> (done && r.st == ST_IDLE))
    else $error("four-state cycle not completed after T4");

  // three-state cycle never reaches a fourth state
  AST_TS_NO_T4: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.st != ST_IDLE && r.fmt == ebms_pkg::EBMS_THREE) |-> (r.st != ST_T4))
    else $error("three-state cycle entered T4");

  // latch strobe only ever rises for the four-state format
  AST_ALE_FORMAT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.st != ST_IDLE && r.fmt != ebms_pkg::EBMS_FOUR) |-> !bus.ale)
    else $error("latch strobe raised outside four-state format");

  // the next request waits until the sequencer is idle
  AST_BUSY_REFUSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (r.st != ST_IDLE) |-> !req_ready)
    else $error("request accepted while busy");

endmodule : ebms_sequencer

// file: ebms_periph.sv
`timescale 1ns/100ps
module ebms_periph (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire ebms_pkg::ebms_bus_t bus,
  input  wire logic [3:0]         wait_cycles,
  output logic [7:0]              data_in,
  output logic                    wait_n
);
  logic [3:0] cnt;
  logic [7:0] last;
  logic       sel_d;
  logic       sel;
  logic       rd_act;

  // selection and read decode
  assign sel    = ~&bus.chip_select_line_n;
  assign rd_act = sel && (bus.rd_n == 1'b0);

  // wait pin pulled low from the clock after select, well before T2 ends
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt   <= 4'h0;
      last  <= 8'h00;
      sel_d <= 1'b0;
    end else begin
      sel_d <= sel;
      if (sel && !sel_d) cnt <= wait_cycles;
      else if (cnt != 4'h0) cnt <= cnt - 4'h1;
      if (rd_act) last <= data_in;
    end
  end

  // released data line shows the inverse of the last byte
  assign wait_n  = (cnt == 4'h0);
  assign data_in = rd_act ? (bus.addr[7:0] ^ 8'h5a) : ~last;
endmodule : ebms_periph

// file: ebms_sequencer_tb.sv
`timescale 1ns/100ps
module ebms_sequencer_tb;
  logic                                      sys_clk;
  logic                                      rst_n;
  logic                                      req_ready;
  logic                                      done;
  logic                                      wait_n;
  ebms_pkg::ebms_cfg_t [ebms_pkg::NUM_CS-1:0] cfg;
  ebms_pkg::ebms_req_t                       req;
  ebms_pkg::ebms_bus_t                       bus;
  logic [7:0]                                rdata;
  logic [7:0]                                data_in;
  logic [3:0]                                wait_cycles;
  int                                        n_fail;
  int                                        tests_run;
  int                                        cyc;
  int                                        stb;
  int                                        ale_n;
  int                                        mux_n;

  ebms_sequencer uut (.sys_clk(sys_clk), .rst_n(rst_n), .cfg(cfg), .req(req),
    .req_ready(req_ready), .done(done), .rdata(rdata), .bus(bus), .data_in(data_in),
    .wait_n(wait_n));

  ebms_periph far (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus),
    .wait_cycles(wait_cycles), .data_in(data_in), .wait_n(wait_n));

  // clock generation
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task conclude;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // one bus cycle, observed clock by clock until done
  task run(input ebms_pkg::ebms_fmt_t f, input logic mx, input logic [3:0] ln,
           input logic wr, input logic io, input logic [1:0] cs,
           input logic [23:0] a, input logic [3:0] nw);
    @(posedge sys_clk); #1;
    cfg[cs] = '{f, mx, ln};
    wait_cycles = nw;
    req = '{1'b1, wr, io, cs, a, a[7:0] ^ 8'h33};
    @(posedge sys_clk); #1;
    req.valid = 1'b0;
    cyc = 0; stb = 0; ale_n = 0; mux_n = 0;
    while (done !== 1'b1 && cyc < 300) begin
      if (bus.rd_n === 1'b0 || bus.wr_n === 1'b0) begin
        stb++;
        check({bus.memory_request_n, bus.io_request_n}, io ? 2'h2 : 2'h1);
      end
      check(req_ready, 1'b0);
      if (bus.wr_n === 1'b0) check({bus.doe, bus.dout}, {1'b1, a[7:0] ^ 8'h33});
      if (bus.chip_select_line_n !== ebms_pkg::CS_IDLE) begin
        check(bus.chip_select_line_n, 4'(~(4'h1 << cs)));
        check(bus.addr, a);
      end
      if (bus.ale === 1'b1) ale_n++;
      if (bus.doe === 1'b1 && bus.dout === a[7:0] && bus.rd_n === 1'b1) mux_n++;
      @(posedge sys_clk); #1;
      cyc++;
    end
    check({bus.chip_select_line_n, bus.memory_request_n, bus.io_request_n,
           bus.rd_n, bus.wr_n}, 8'hff);
    if (!wr) check(rdata, a[7:0] ^ 8'h5a);
  endtask : run

  task t_three_read;
    int lens[3] = '{1, 2, 15};
    foreach (lens[i]) begin
      run(ebms_pkg::EBMS_THREE, 1'b0, 4'(lens[i]), 1'b0, 1'b0, 2'h0, 24'h1234a0 + 24'(i), 4'h0);
      check(cyc, 3 * lens[i]);
      check(stb, 2 * lens[i]);
    end
    $display("test three_read done");
  endtask : t_three_read

  task t_three_write;
    run(ebms_pkg::EBMS_THREE, 1'b0, 4'h2, 1'b1, 1'b1, 2'h1, 24'h00ab5c, 4'h0);
    check(cyc, 6);
    check(stb, 4);
    $display("test three_write done");
  endtask : t_three_write

  task t_three_wait;
    run(ebms_pkg::EBMS_THREE, 1'b0, 4'h1, 1'b0, 1'b0, 2'h2, 24'h0a0b0c, 4'h3);
    check(cyc, 6);
    $display("test three_wait done");
  endtask : t_three_wait

  task t_four_read;
    run(ebms_pkg::EBMS_FOUR, 1'b0, 4'h2, 1'b0, 1'b0, 2'h2, 24'h55aa10, 4'h0);
    check(cyc, 8);
    check(stb, 4);
    check(ale_n, 1);
    check(mux_n, 0);
    $display("test four_read done");
  endtask : t_four_read

  task t_four_mux;
    run(ebms_pkg::EBMS_FOUR, 1'b1, 4'h1, 1'b0, 1'b1, 2'h3, 24'h0102c3, 4'h0);
    check(cyc, 4);
    check(ale_n, 1);
    check(mux_n > 0, 1);
    $display("test four_mux done");
  endtask : t_four_mux

  task t_four_wait;
    run(ebms_pkg::EBMS_FOUR, 1'b0, 4'h2, 1'b0, 1'b0, 2'h0, 24'h777777, 4'h3);
    check(cyc, 9);
    $display("test four_wait done");
  endtask : t_four_wait

  task t_native;
    run(ebms_pkg::EBMS_NATIVE, 1'b0, 4'h1, 1'b0, 1'b0, 2'h0, 24'h000042, 4'h0);
    check(cyc, 1);
    $display("test native done");
  endtask : t_native

  // reset, then the scenarios in turn
  initial begin
    n_fail = 0;
    tests_run = 0;
    cfg = '0;
    req = '0;
    wait_cycles = 4'h0;
    rst_n = 1'b0;
    repeat (6) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    check({req_ready, done, bus.ale, bus.doe}, 4'h8);
    t_three_read;
    t_three_write;
    t_three_wait;
    t_four_read;
    t_four_mux;
    t_four_wait;
    t_native;
    conclude;
  end

  // watchdog against a hung handshake
  initial begin
    #200000;
    n_fail++;
    conclude;
  end
endmodule : ebms_sequencer_tb
